// ---- twd_pkg.sv ----
// Package with register map, field positions and constants of the timer/watchdog block.
package twd_pkg;
	localparam logic [2:0] ADDR_CONFIG = 3'h0;
	localparam logic [2:0] ADDR_PRESCALER = 3'h1;
	localparam logic [2:0] ADDR_PERIOD_LO = 3'h2;
	localparam logic [2:0] ADDR_PERIOD_HI = 3'h3;
	localparam logic [2:0] ADDR_CONTROL_STATUS = 3'h4;
	localparam logic [2:0] ADDR_RELOAD_VALUE = 3'h5;
	localparam logic [2:0] ADDR_SERVICE_MATCH = 3'h6;
	localparam logic [2:0] ADDR_STATUS = 3'h7;
	localparam int CSR_RESTART = 0;
	localparam int CSR_TC = 1;
	localparam int CSR_IRQ_EN = 2;
	localparam int CFG_LOCK_CFG = 0;
	localparam int CFG_LOCK_PRESCALER = 1;
	localparam int CFG_LOCK_TIMER0 = 2;
	localparam int CFG_LOCK_RELOAD = 3;
	localparam int CFG_CLOCK_SELECT = 4;
	localparam int CFG_MATCH_ENABLE = 5;
	localparam logic [5:0] CFG_MASK = 6'h3F;
	localparam logic [7:0] CSR_RESET = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'h0F;
	localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
	localparam logic [2:0] PRESCALER_MAX = 3'h5;
	localparam logic [7:0] SERVICE_KEY = 8'h5C;
	localparam logic [7:0] LOCKED_READ = 8'h00;
endpackage

// ---- timer0_and_watchdog_service.sv ----
// Timer T0 with restart and terminal count, and watchdog servicing logic.
`timescale 1ns/1ns
// Overview of operation
// - Writing one to restart reloads the preset on the next input clock edge.
// - Restart clears itself on that same reload edge; writing zero does nothing.
// - Terminal count sets at zero, clears on control read, ignores writes.
// - With interrupt enable set, each zero count pulses the timer interrupt.
// - Control/status: restart bit 0, terminal count bit 1, enable bit 2; reset zero.
// - Reload-value register is eight bits, write-only, resets to 0F hex.
// - First reload write starts the watchdog; later writes restart with new value.
// - With match enabled, writing 5C hex reloads counter from reload value.
// - With match enabled, any other written value causes a watchdog error.
// - Two match writes within one watchdog clock cycle cause an error.
// - With match disabled, match-register writes are ignored entirely.
// - Prescaled slow clock selects among six rates, slow clock /32 to /1.
// - Timer output rate is prescaled rate divided by preset plus one.
// - A configuration bit selects the watchdog clock source.
// - After start, no service within a nonzero reload count of watchdog clocks causes an error.
// - Select zero uses timer output clock; one uses prescaled slow clock.
// - Any watchdog error resets the whole device.
// - Locked registers ignore writes, read undefined, stay locked until reset.
// - Timer reloads its preset on every underflow and keeps counting.
module timer0_and_watchdog_service
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic low_speed_clock,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic timer0_irq,
	output logic device_reset_req
);
	import twd_pkg::*;

	logic [5:0] watchdog_config;
	logic [2:0] slow_clock_prescaler;
	logic [15:0] timer0_period_register;
	logic [15:0] timer0_count;
	logic restart;
	logic terminal_count_flag;
	logic timer0_irq_enable;
	logic [7:0] watchdog_reload_value;
	logic [7:0] watchdog_count;
	logic watchdog_running;
	logic serviced_this_tick;
	logic watchdog_error;
	logic bad_key_error;
	logic double_service_error;
	logic late_service_error;
	logic slow_prev;
	logic [4:0] prescale_count;
	logic prescaled_slow_clock;
	logic timer0_output_clock;
	logic watchdog_tick;
	logic wr_config;
	logic wr_prescaler;
	logic wr_period_lo;
	logic wr_period_hi;
	logic wr_csr;
	logic wr_reload;
	logic wr_match;
	logic rd_csr;
	logic match_ok;
	logic match_bad;
	logic [4:0] divide_mask;
	logic access_ok;

	// Mask of prescaler bits that must be all ones for a divided edge.
	function automatic logic [4:0] mask_of(input logic [2:0] sel);
		logic [4:0] m;
		m = 5'h00;
		unique case (sel)
			3'h0: m = 5'h00;
			3'h1: m = 5'h01;
			3'h2: m = 5'h03;
			3'h3: m = 5'h07;
			3'h4: m = 5'h0F;
			default: m = 5'h1F;
		endcase
		return m;
	endfunction

	// Lock decode shared by the write strobes and the read multiplexer.
	function automatic logic is_locked(input logic [2:0] a,
		input logic [5:0] cfg);
		logic l;
		l = 1'b0;
		unique case (a)
			ADDR_CONFIG: l = cfg[CFG_LOCK_CFG];
			ADDR_PRESCALER: l = cfg[CFG_LOCK_PRESCALER];
			ADDR_PERIOD_LO: l = cfg[CFG_LOCK_TIMER0];
			ADDR_PERIOD_HI: l = cfg[CFG_LOCK_TIMER0];
			ADDR_CONTROL_STATUS: l = cfg[CFG_LOCK_TIMER0];
			ADDR_RELOAD_VALUE: l = cfg[CFG_LOCK_RELOAD];
			ADDR_SERVICE_MATCH: l = 1'b0;
			ADDR_STATUS: l = 1'b0;
		endcase
		return l;
	endfunction

	// Register write decode; locked registers drop writes.
	always_comb
	begin
		access_ok = !is_locked(addr, watchdog_config);
		wr_config = wr && addr == ADDR_CONFIG
			&& access_ok;
		wr_prescaler = wr && addr == ADDR_PRESCALER
			&& access_ok;
		wr_period_lo = wr && addr == ADDR_PERIOD_LO
			&& access_ok;
		wr_period_hi = wr && addr == ADDR_PERIOD_HI
			&& access_ok;
		wr_csr = wr && addr == ADDR_CONTROL_STATUS
			&& access_ok;
		wr_reload = wr && addr == ADDR_RELOAD_VALUE
			&& access_ok;
		wr_match = wr && addr == ADDR_SERVICE_MATCH
			&& watchdog_config[CFG_MATCH_ENABLE];
		rd_csr = rd && addr == ADDR_CONTROL_STATUS
			&& access_ok;
		match_ok = wr_match && wdata == SERVICE_KEY;
		match_bad = wr_match && wdata != SERVICE_KEY;
		divide_mask = mask_of(slow_clock_prescaler);
	end

	// Configuration bits are set-only until reset.
	// Set-only bits stop a runaway program from undoing a lock.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			watchdog_config <= 6'h00;
		else if (wr_config)
			watchdog_config <= watchdog_config | (wdata[5:0] & CFG_MASK);
	end

	// Reserved divider codes are refused so the rate stays legal.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			slow_clock_prescaler <= 3'h0;
		else if (wr_prescaler && wdata[2:0] <= PRESCALER_MAX)
			slow_clock_prescaler <= wdata[2:0];
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			timer0_period_register <= PERIOD_RESET;
		else if (wr_period_lo)
			timer0_period_register[7:0] <= wdata;
		else if (wr_period_hi)
			timer0_period_register[15:8] <= wdata;
	end

	// The slow clock is taken as synchronous; its rising edges drive a
	// five-bit ripple count, and the selected prefix marks a divided edge.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			slow_prev <= 1'b0;
			prescale_count <= 5'h00;
		end
		else
		begin
			slow_prev <= low_speed_clock;
			if (low_speed_clock && !slow_prev)
				prescale_count <= prescale_count + 5'h01;
		end
	end

	assign prescaled_slow_clock = low_speed_clock && !slow_prev
		&& (prescale_count & divide_mask) == divide_mask;

	// Output clock pulses on underflow, once per preset+1 input edges.
	assign timer0_output_clock = prescaled_slow_clock && !restart
		&& timer0_count == 16'h0000;

	assign watchdog_tick = watchdog_config[CFG_CLOCK_SELECT]
		? prescaled_slow_clock : timer0_output_clock;

	// Timer counter: restart or underflow reloads the preset.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			timer0_count <= PERIOD_RESET;
		else if (prescaled_slow_clock)
		begin
			if (restart || timer0_count == 16'h0000)
				timer0_count <= timer0_period_register;
			else
				timer0_count <= timer0_count - 16'h0001;
		end
	end

	// Restart bit: set by software, cleared on the reload edge.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			restart <= CSR_RESET[CSR_RESTART];
		else if (wr_csr && wdata[CSR_RESTART])
			restart <= 1'b1;
		else if (prescaled_slow_clock)
			restart <= 1'b0;
	end

	// Terminal count: the set wins over a read that clears it.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			terminal_count_flag <= CSR_RESET[CSR_TC];
		else if (timer0_output_clock)
			terminal_count_flag <= 1'b1;
		else if (rd_csr)
			terminal_count_flag <= 1'b0;
	end

	// The enable is the only plain read/write bit of the control register.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			timer0_irq_enable <= CSR_RESET[CSR_IRQ_EN];
		else if (wr_csr)
			timer0_irq_enable <= wdata[CSR_IRQ_EN];
	end

	// One-cycle interrupt pulse per zero count.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			timer0_irq <= 1'b0;
		else
			timer0_irq <= timer0_output_clock && timer0_irq_enable;
	end

	// Write-only: a read of this address returns zero.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			watchdog_reload_value <= RELOAD_RESET;
		else if (wr_reload)
			watchdog_reload_value <= wdata;
	end

	// Watchdog starts on the first reload write.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			watchdog_running <= 1'b0;
		else if (wr_reload)
			watchdog_running <= 1'b1;
	end

	// Watchdog counter: service reloads, each tick after start decrements.
	// A reload of zero parks the count; that alone raises no error.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			watchdog_count <= RELOAD_RESET;
		else if (wr_reload)
			watchdog_count <= wdata;
		else if (match_ok)
			watchdog_count <= watchdog_reload_value;
		else if (watchdog_running && watchdog_tick
			&& watchdog_count != 8'h00)
			watchdog_count <= watchdog_count - 8'h01;
	end

	// Marks a service already made in the current watchdog clock cycle.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			serviced_this_tick <= 1'b0;
		else if (match_ok)
			serviced_this_tick <= 1'b1;
		else if (watchdog_tick)
			serviced_this_tick <= 1'b0;
	end

	// Errors are sticky; only the device reset they cause clears them.
	// One flag per cause keeps the set term of each flag simple.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			bad_key_error <= 1'b0;
		else if (match_bad)
			bad_key_error <= 1'b1;
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			double_service_error <= 1'b0;
		else if (wr_match && serviced_this_tick)
			double_service_error <= 1'b1;
	end

	// A service or reload on the expiring tick is in time, so no error.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			late_service_error <= 1'b0;
		else if (watchdog_running && watchdog_tick && !match_ok
			&& !wr_reload && watchdog_count == 8'h01)
			late_service_error <= 1'b1;
	end

	assign watchdog_error = bad_key_error | double_service_error
		| late_service_error;

	assign device_reset_req = watchdog_error;

	// Read data one cycle after the strobe; locked reads give a filler.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			rdata <= 8'h00;
		else if (rd && !access_ok)
			rdata <= LOCKED_READ;
		else if (rd)
		begin
			unique case (addr)
				ADDR_CONFIG: rdata <= {2'b00, watchdog_config};
				ADDR_PRESCALER: rdata <= {5'h00, slow_clock_prescaler};
				ADDR_PERIOD_LO: rdata <= timer0_period_register[7:0];
				ADDR_PERIOD_HI: rdata <= timer0_period_register[15:8];
				ADDR_CONTROL_STATUS: rdata <= {5'h00, timer0_irq_enable,
					terminal_count_flag, restart};
				ADDR_RELOAD_VALUE: rdata <= 8'h00;
				ADDR_SERVICE_MATCH: rdata <= 8'h00;
				ADDR_STATUS: rdata <= watchdog_count;
			endcase
		end
	end
endmodule

// ---- twd_checker_sva.sv ----
// Port-level assertion checker for the timer and watchdog block.
`timescale 1ns/1ns
module twd_checker
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic low_speed_clock,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic timer0_irq,
	input wire logic device_reset_req
);
	import twd_pkg::*;
	logic irq_en;
	logic match_en;
	logic started;
	logic sm_wr;
	assign sm_wr = wr && addr == ADDR_SERVICE_MATCH;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// Shadows ignore lock bits, so they hold only while nothing is locked.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			irq_en <= 1'b0;
		else if (wr && addr == ADDR_CONTROL_STATUS)
			irq_en <= wdata[CSR_IRQ_EN];
	end
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			match_en <= 1'b0;
		else if (wr && addr == ADDR_CONFIG && wdata[CFG_MATCH_ENABLE])
			match_en <= 1'b1;
	end
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			started <= 1'b0;
		else if ((wr && addr == ADDR_RELOAD_VALUE) || (sm_wr && match_en))
			started <= 1'b1;
	end
	a_error_sticky: assert property (
		device_reset_req |=> device_reset_req)
		else $error("watchdog reset request dropped");
	a_irq_gated: assert property (
		timer0_irq |-> $past(irq_en))
		else $error("timer interrupt while disabled");
	a_irq_pulse: assert property (
		timer0_irq |=> !timer0_irq)
		else $error("timer interrupt longer than one cycle");
	a_rdata_holds: assert property (
		!$past(rd) |-> $stable(rdata))
		else $error("read data changed without a read");
	a_reload_wo: assert property (
		rd && addr == ADDR_RELOAD_VALUE |=> rdata == 8'h00)
		else $error("reload value register readable");
	a_bad_key: assert property (
		sm_wr && match_en && wdata != SERVICE_KEY |-> ##[1:2] device_reset_req)
		else $error("wrong service value not flagged");
	a_match_off: assert property (
		sm_wr && !match_en && !device_reset_req |=> !device_reset_req)
		else $error("service write acted while disabled");
	a_not_started: assert property (
		!started |-> !device_reset_req)
		else $error("watchdog error before it was started");
endmodule
bind timer0_and_watchdog_service twd_checker twd_checker_inst (.mclk,
	.rstn, .low_speed_clock, .addr, .wdata, .wr, .rd, .rdata,
	.timer0_irq, .device_reset_req);

// ---- tb_top.sv ----
// Self-checking testbench for the timer and watchdog block.
`timescale 1ns/1ns
`define CHK(a, e) \
	begin \
		check_count++; \
		if ((a) !== (e)) \
		begin \
			mismatches++; \
			$display("wrong value at %0t: got %h expected %h", \
				$time, (a), (e)); \
		end \
	end
module tb_top;
	import twd_pkg::*;
	logic mclk = 0, rstn = 0, low_speed_clock = 0, wr = 0, rd = 0, seen;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic timer0_irq, device_reset_req;
	int mismatches = 0, check_count = 0;
	time t0;
	timer0_and_watchdog_service timer0_and_watchdog_service_inst (.mclk,
		.rstn, .low_speed_clock, .addr, .wdata, .wr, .rd, .rdata,
		.timer0_irq, .device_reset_req);
	always #10 mclk = ~mclk;
	// The slow clock is kept at one eighth of mclk, well inside its limit.
	always
	begin
		repeat (4) @(posedge mclk);
		low_speed_clock <= ~low_speed_clock;
	end
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic reset_dut;
		rstn <= 1'b0;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
	endtask
	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [2:0] a, input logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask
	task automatic wait_for(input bit irq, input int lim);
		int n;
		n = 0;
		do
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		while ((irq ? timer0_irq : device_reset_req) !== 1'b1 && n < lim);
		`CHK(irq ? timer0_irq : device_reset_req, 1'b1)
	endtask
	initial
	begin
		#1000000;
		mismatches++;
		results();
	end
	initial
	begin
		reset_dut();
		rreg(ADDR_CONTROL_STATUS, CSR_RESET);
		rreg(ADDR_STATUS, RELOAD_RESET);
		rreg(ADDR_RELOAD_VALUE, 8'h00);
		wreg(ADDR_SERVICE_MATCH, 8'h11);
		#1;
		`CHK(device_reset_req, 1'b0)
		wreg(ADDR_PERIOD_LO, 8'h03);
		wreg(ADDR_PERIOD_HI, 8'h00);
		wreg(ADDR_CONTROL_STATUS, 8'h07);
		wait_for(1'b1, 200);
		rreg(ADDR_CONTROL_STATUS, 8'h06);
		rreg(ADDR_CONTROL_STATUS, 8'h04);
		for (int k = 0; k < 6; k++)
		begin
			wreg(ADDR_PRESCALER, 8'(k));
			wait_for(1'b1, 3000);
			wait_for(1'b1, 3000);
			t0 = $time;
			wait_for(1'b1, 3000);
			`CHK($time - t0, time'(640 << k))
		end
		wreg(ADDR_PRESCALER, 8'h00);
		wreg(ADDR_CONTROL_STATUS, 8'h00);
		seen = 1'b0;
		repeat (100)
		begin
			@(posedge mclk);
			#1;
			seen |= timer0_irq;
		end
		`CHK(seen, 1'b0)
		$display("test timer done");
		wreg(ADDR_CONFIG, 8'h30);
		wreg(ADDR_RELOAD_VALUE, 8'h05);
		repeat (4)
		begin
			repeat (30) @(posedge mclk);
			wreg(ADDR_SERVICE_MATCH, SERVICE_KEY);
		end
		#1;
		`CHK(device_reset_req, 1'b0)
		$display("test service done");
		for (int k = 0; k < 3; k++)
		begin
			reset_dut();
			wreg(ADDR_PERIOD_LO, 8'h03);
			wreg(ADDR_PERIOD_HI, 8'h00);
			wreg(ADDR_CONTROL_STATUS, 8'h01);
			wreg(ADDR_CONFIG, k == 2 ? 8'h20 : 8'h30);
			repeat (200) @(posedge mclk);
			#1;
			`CHK(device_reset_req, 1'b0)
			wreg(ADDR_RELOAD_VALUE, 8'h05);
			@(posedge low_speed_clock);
			repeat (3) @(posedge mclk);
			if (k == 0)
				wreg(ADDR_SERVICE_MATCH, 8'h5D);
			if (k == 1)
			begin
				wreg(ADDR_SERVICE_MATCH, SERVICE_KEY);
				wreg(ADDR_SERVICE_MATCH, SERVICE_KEY);
			end
			if (k == 2)
			begin
				repeat (100) @(posedge mclk);
				#1;
				`CHK(device_reset_req, 1'b0)
			end
			wait_for(1'b0, k == 2 ? 200 : 3);
			$display("test watchdog case %0d done", k);
		end
		reset_dut();
		wreg(ADDR_PRESCALER, 8'h00);
		wreg(ADDR_PERIOD_LO, 8'h03);
		wreg(ADDR_PERIOD_HI, 8'h00);
		wreg(ADDR_CONFIG, 8'h10);
		wreg(ADDR_RELOAD_VALUE, 8'h05);
		wreg(ADDR_CONFIG, 8'h2F);
		repeat (3)
		begin
			repeat (14) @(posedge mclk);
			wreg(ADDR_SERVICE_MATCH, SERVICE_KEY);
		end
		rreg(ADDR_CONFIG, LOCKED_READ);
		rreg(ADDR_PERIOD_LO, LOCKED_READ);
		wreg(ADDR_RELOAD_VALUE, 8'h00);
		#1;
		`CHK(device_reset_req, 1'b0)
		wait_for(1'b0, 60);
		$display("test lock done");
		results();
	end
endmodule
